/* verilog/disk_power_mode_manager.sv */
`include "pwr_mode_defines.svh"

// Functional notes
// - sleep is left only by soft or hard reset, always into standby
// - standby: heads unloaded, spindle stopped, commands still accepted at once
// - idle: spindle and servo run, any command accepted and started at once
// - unloaded idle: spindle at full speed with heads parked off media
// - spin-up always precedes media access after a stopped spindle or power down
// - spindle-stop commands complete within 1 ms; spin-down may continue later
// - any spindle stop or power down engages the head lock at outer parking
module disk_power_mode_manager
    import pwr_mode_pkg::*;
#(
    parameter int unsigned CMD_DONE_LIMIT = `CMD_DONE_CYC
)
(
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic SOFT_RESET,
    input wire logic CMD_VALID,
    input wire logic [`CMD_W-1:0] CMD_CODE,
    input wire logic SPIN_AT_SPEED,
    input wire logic SPIN_STOPPED,
    input wire logic HEADS_LOADED,
    input wire logic MEDIA_OP_DONE,
    output logic CMD_ACCEPT,
    output logic CMD_DONE,
    output logic CMD_LATE,
    output logic SPINDLE_ON,
    output logic HEADS_LOAD,
    output logic HEAD_LOCK,
    output logic MEDIA_ACTIVE,
    output logic DRIVE_READY,
    output logic [8:0] MODE
);
    logic rst_s1_q;
    logic rst_s2_q;
    logic rst_n;

    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    assign rst_n = rst_s2_q;

    function automatic logic is_media_cmd(input logic [`CMD_W-1:0] c);
        is_media_cmd = (c == `CMD_SEEK) || (c == `CMD_READ) || (c == `CMD_WRITE);
    endfunction : is_media_cmd

    function automatic logic is_stop_cmd(input logic [`CMD_W-1:0] c);
        is_stop_cmd = (c == `CMD_STANDBY) || (c == `CMD_SLEEP);
    endfunction : is_stop_cmd

    mode_e mode_q;
    mode_e mode_d;
    // the command that is pending until spin-up and, except for unload, head load are done
    logic [`CMD_W-1:0] pend_q;
    logic [`CMD_W-1:0] pend_d;
    logic accept_d;
    logic done_d;
    logic accept_q;
    logic done_q;
    logic late_q;
    logic late_d;
    logic spin_q;
    logic spin_d;
    logic load_q;
    logic load_d;
    logic lock_q;
    logic lock_d;
    logic active_q;
    logic ready_q;
    logic stop_start;
    logic stop_late;

    // stop commands finish in one cycle, so the timer only guards against a regression
    assign stop_start = CMD_VALID && is_stop_cmd(CMD_CODE) && accept_d;

    cmd_timer #(
        .LIMIT(CMD_DONE_LIMIT)
    ) u_stop_timer (
        .clk(MCLK),
        .rst_n(rst_n),
        .start(stop_start),
        .stop(done_q),
        .expired(stop_late)
    );

    always_comb
    begin
        mode_d = mode_q;
        pend_d = pend_q;
        accept_d = 1'b0;
        done_d = 1'b0;
        late_d = late_q | stop_late;
        unique case (mode_q)
            ST_SLEEP:
            begin
                if (SOFT_RESET)
                    mode_d = ST_STANDBY;
            end
            ST_STANDBY:
            begin
                if (CMD_VALID)
                begin
                    accept_d = 1'b1;
                    if (CMD_CODE == `CMD_SLEEP)
                    begin
                        mode_d = ST_SLEEP;
                        done_d = 1'b1;
                    end
                    else if (CMD_CODE == `CMD_STANDBY)
                        done_d = 1'b1;
                    else
                    begin
                        pend_d = CMD_CODE;
                        mode_d = ST_SPINUP;
                    end
                end
            end
            ST_SPINUP:
            begin
                if (SPIN_AT_SPEED)
                    mode_d = (pend_q == `CMD_UNLOAD) ? ST_UNLOAD_IDLE : ST_LOADING;
            end
            ST_LOADING:
            begin
                if (HEADS_LOADED)
                begin
                    if (is_media_cmd(pend_q))
                        mode_d = (pend_q == `CMD_SEEK) ? ST_SEEK :
                                 (pend_q == `CMD_READ) ? ST_READ : ST_WRITE;
                    else
                    begin
                        mode_d = ST_IDLE;
                        done_d = 1'b1;
                    end
                end
            end
            ST_UNLOAD_IDLE:
            begin
                if (CMD_VALID)
                begin
                    accept_d = 1'b1;
                    if (is_stop_cmd(CMD_CODE))
                    begin
                        mode_d = (CMD_CODE == `CMD_SLEEP) ? ST_SLEEP : ST_STANDBY;
                        done_d = 1'b1;
                    end
                    else if (CMD_CODE == `CMD_UNLOAD)
                        done_d = 1'b1;
                    else
                    begin
                        pend_d = CMD_CODE;
                        mode_d = ST_LOADING;
                    end
                end
            end
            ST_IDLE:
            begin
                if (CMD_VALID)
                begin
                    accept_d = 1'b1;
                    if (is_stop_cmd(CMD_CODE))
                    begin
                        mode_d = (CMD_CODE == `CMD_SLEEP) ? ST_SLEEP : ST_STANDBY;
                        done_d = 1'b1;
                    end
                    else if (CMD_CODE == `CMD_UNLOAD)
                    begin
                        mode_d = ST_UNLOAD_IDLE;
                        done_d = 1'b1;
                    end
                    else if (is_media_cmd(CMD_CODE))
                        mode_d = (CMD_CODE == `CMD_SEEK) ? ST_SEEK :
                                 (CMD_CODE == `CMD_READ) ? ST_READ : ST_WRITE;
                    else
                        done_d = 1'b1;
                end
            end
            ST_SEEK, ST_READ, ST_WRITE:
            begin
                if (MEDIA_OP_DONE)
                begin
                    mode_d = ST_IDLE;
                    done_d = 1'b1;
                end
            end
            default:
                mode_d = ST_STANDBY;
        endcase
        if (SOFT_RESET && mode_q != ST_SLEEP)
        begin
            // soft reset drops pending work; a cut spin-up falls back to standby so that
            // media access is never reached before the spindle has come up to speed
            accept_d = 1'b0;
            done_d = 1'b0;
            mode_d = (spin_q && mode_q != ST_SPINUP) ? ST_IDLE : ST_STANDBY;
        end
    end

    always_comb
    begin
        spin_d = 1'b0;
        load_d = 1'b0;
        unique case (mode_d)
            ST_SPINUP: spin_d = 1'b1;
            ST_LOADING, ST_IDLE, ST_SEEK, ST_READ, ST_WRITE:
            begin
                spin_d = 1'b1;
                load_d = 1'b1;
            end
            ST_UNLOAD_IDLE: spin_d = 1'b1;
            ST_STANDBY, ST_SLEEP: spin_d = 1'b0;
            default: spin_d = 1'b0;
        endcase
        // lock held whenever the spindle is commanded off or still coasting down
        lock_d = !spin_d || !HEADS_LOADED && !load_d || !SPIN_STOPPED && !spin_d;
    end

    always_ff @(posedge MCLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // hard reset from any mode, sleep included, lands in standby
            mode_q <= ST_STANDBY;
            pend_q <= `CMD_NONE;
            accept_q <= 1'b0;
            done_q <= 1'b0;
            late_q <= 1'b0;
            spin_q <= 1'b0;
            load_q <= 1'b0;
            lock_q <= 1'b1;
            active_q <= 1'b0;
            ready_q <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            pend_q <= pend_d;
            accept_q <= accept_d;
            done_q <= done_d;
            late_q <= late_d;
            spin_q <= spin_d;
            load_q <= load_d;
            lock_q <= lock_d;
            active_q <= (mode_d == ST_SEEK) || (mode_d == ST_READ) || (mode_d == ST_WRITE);
            ready_q <= (mode_d == ST_IDLE);
        end
    end

    assign CMD_ACCEPT = accept_q;
    assign CMD_DONE = done_q;
    assign CMD_LATE = late_q;
    assign SPINDLE_ON = spin_q;
    assign HEADS_LOAD = load_q;
    assign HEAD_LOCK = lock_q;
    assign MEDIA_ACTIVE = active_q;
    assign DRIVE_READY = ready_q;
    assign MODE = mode_q;
endmodule : disk_power_mode_manager

/* verilog/pwr_mode_defines.svh */
`ifndef PWR_MODE_DEFINES_SVH
`define PWR_MODE_DEFINES_SVH

// command completion deadline for spindle-stop commands
`define CMD_DONE_MAX_NS 1000000
`define CLK_PERIOD_NS 4
`define CMD_DONE_CYC (`CMD_DONE_MAX_NS / `CLK_PERIOD_NS)
// nominal spindle speed in unloaded idle and idle
`define FULL_RPM 16'h1C20
// command codes on the command port
`define CMD_W 3
`define CMD_NONE 3'h0
`define CMD_IDLE 3'h1
`define CMD_STANDBY 3'h2
`define CMD_SLEEP 3'h3
`define CMD_UNLOAD 3'h4
`define CMD_SEEK 3'h5
`define CMD_READ 3'h6
`define CMD_WRITE 3'h7

`endif

/* verilog/pwr_mode_pkg.sv */
package pwr_mode_pkg;

typedef enum logic [8:0] {
    ST_SPINUP = 9'h001,
    ST_SEEK = 9'h002,
    ST_WRITE = 9'h004,
    ST_READ = 9'h008,
    ST_UNLOAD_IDLE = 9'h010,
    ST_IDLE = 9'h020,
    ST_STANDBY = 9'h040,
    ST_SLEEP = 9'h080,
    ST_LOADING = 9'h100
} mode_e;

endpackage : pwr_mode_pkg

/* verilog/cmd_timer.sv */
`include "pwr_mode_defines.svh"

// counts cycles while armed; flags expiry in the cycle the count reaches the limit
module cmd_timer
    import pwr_mode_pkg::*;
#(
    parameter int unsigned LIMIT = `CMD_DONE_CYC
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic stop,
    output logic expired
);
    logic [17:0] cnt_q;
    logic [17:0] cnt_d;
    logic run_q;
    logic run_d;
    logic exp_q;
    logic exp_d;

    always_comb
    begin
        cnt_d = cnt_q;
        run_d = run_q;
        exp_d = 1'b0;
        if (start)
        begin
            cnt_d = 18'h00000;
            run_d = 1'b1;
        end
        else if (stop)
        begin
            run_d = 1'b0;
        end
        else if (run_q)
        begin
            if (cnt_q == 18'(LIMIT - 1))
            begin
                exp_d = 1'b1;
                run_d = 1'b0;
            end
            cnt_d = cnt_q + 18'h00001;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 18'h00000;
            run_q <= 1'b0;
            exp_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            exp_q <= exp_d;
        end
    end

    assign expired = exp_q;
endmodule : cmd_timer

/* verif/pwr_mode_monitor.sv */
`include "pwr_mode_defines.svh"
module pwr_mode_monitor
    import pwr_mode_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic SOFT_RESET,
    input wire logic CMD_VALID,
    input wire logic [`CMD_W-1:0] CMD_CODE,
    input wire logic MEDIA_OP_DONE,
    input wire logic HEADS_LOADED,
    input wire logic CMD_ACCEPT,
    input wire logic CMD_DONE,
    input wire logic SPINDLE_ON,
    input wire logic HEADS_LOAD,
    input wire logic HEAD_LOCK,
    input wire logic MEDIA_ACTIVE,
    input wire logic [8:0] MODE
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESET_N);
    logic go;
    assign go = CMD_VALID && !SOFT_RESET;
    a_sleep_hold: assert property (
        MODE == ST_SLEEP && !SOFT_RESET |=> MODE == ST_SLEEP)
        else $error("sleep left without reset");
    a_sleep_wake: assert property (
        MODE == ST_SLEEP && SOFT_RESET |=> MODE == ST_STANDBY)
        else $error("soft reset did not wake to standby");
    a_standby_off: assert property (
        MODE == ST_STANDBY |-> !SPINDLE_ON && !HEADS_LOAD && HEAD_LOCK)
        else $error("standby with spindle or heads active");
    a_standby_take: assert property (
        MODE == ST_STANDBY && go && CMD_CODE != 3'h0 |=> CMD_ACCEPT)
        else $error("command refused in standby");
    a_idle_start: assert property (
        MODE == ST_IDLE && go && CMD_CODE >= 3'h5 |=> CMD_ACCEPT && MEDIA_ACTIVE)
        else $error("media command not started from idle");
    a_unload_spin: assert property (
        MODE == ST_UNLOAD_IDLE |-> SPINDLE_ON && !HEADS_LOAD)
        else $error("unload idle outputs wrong");
    // the lock follows the heads leaving the media, so it is checked once they are off
    a_unload_lock: assert property (
        MODE == ST_UNLOAD_IDLE && !HEADS_LOADED |=> MODE != ST_UNLOAD_IDLE || HEAD_LOCK)
        else $error("parked heads not locked in unload idle");
    a_spinup_first: assert property (
        MODE == ST_STANDBY |=> MODE inside {ST_STANDBY, ST_SPINUP, ST_SLEEP})
        else $error("standby left without spin-up");
    a_media_entry: assert property (
        $rose(MEDIA_ACTIVE) |-> $past(MODE) inside {ST_IDLE, ST_LOADING})
        else $error("media mode entered from wrong mode");
    a_stop_fast: assert property (
        MODE inside {ST_IDLE, ST_UNLOAD_IDLE} && go && CMD_CODE inside {3'h2, 3'h3}
        |=> CMD_DONE && !SPINDLE_ON)
        else $error("stop command not completed at once");
    a_lock_stop: assert property (
        !SPINDLE_ON |-> HEAD_LOCK)
        else $error("heads unlocked with spindle off");
    a_media_back: assert property (
        MEDIA_ACTIVE && MEDIA_OP_DONE && !SOFT_RESET |=> MODE == ST_IDLE && CMD_DONE)
        else $error("media command did not return to idle");
endmodule : pwr_mode_monitor
bind disk_power_mode_manager pwr_mode_monitor u_mon (.MCLK, .RESET_N, .SOFT_RESET, .CMD_VALID,
    .CMD_CODE, .MEDIA_OP_DONE, .HEADS_LOADED, .CMD_ACCEPT, .CMD_DONE, .SPINDLE_ON, .HEADS_LOAD,
    .HEAD_LOCK, .MEDIA_ACTIVE, .MODE);

/* verif/drive_mech_model.sv */
module drive_mech_model
(
    input wire logic clk,
    input wire logic spindle_on,
    input wire logic heads_load,
    input wire logic [3:0] lat,
    output logic at_speed,
    output logic stopped,
    output logic loaded
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] spd = 4'h0;
    logic [3:0] hd = 4'h0;
    // spin-down coasts one speed step per cycle, so a stop never reads as stopped at once
    always @(posedge clk)
    begin
        if (spindle_on)
            spd <= (spd < lat) ? spd + 4'h1 : lat;
        else if (spd != 4'h0)
            spd <= spd - 4'h1;
        hd <= !heads_load ? 4'h0 : (at_speed && hd < lat) ? hd + 4'h1 : hd;
    end
    assign at_speed = (spd == lat);
    assign stopped = (spd == 4'h0);
    assign loaded = heads_load && (hd == lat);
endmodule : drive_mech_model

/* verif/disk_power_mode_manager_test.sv */
`include "pwr_mode_defines.svh"
module disk_power_mode_manager_test
    import pwr_mode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic soft_rst = 1'b0;
    logic cmd_valid = 1'b0;
    logic [2:0] cmd_code = 3'h0;
    logic op_done = 1'b0;
    logic [3:0] lat = 4'h3;
    logic at_speed, stopped, loaded, acc, done, late, spin, hload, lock, mact, rdy;
    logic [8:0] mode;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    disk_power_mode_manager #(.CMD_DONE_LIMIT(16)) dut (.MCLK(mclk), .RESET_N(reset_n),
        .SOFT_RESET(soft_rst), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code),
        .SPIN_AT_SPEED(at_speed), .SPIN_STOPPED(stopped), .HEADS_LOADED(loaded),
        .MEDIA_OP_DONE(op_done), .CMD_ACCEPT(acc), .CMD_DONE(done), .CMD_LATE(late),
        .SPINDLE_ON(spin), .HEADS_LOAD(hload), .HEAD_LOCK(lock), .MEDIA_ACTIVE(mact),
        .DRIVE_READY(rdy), .MODE(mode));
    drive_mech_model mech (.clk(mclk), .spindle_on(spin), .heads_load(hload), .lat(lat),
        .at_speed(at_speed), .stopped(stopped), .loaded(loaded));
    initial
    begin
        forever #2 mclk = ~mclk;
    end
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask : tick
    task automatic pulse(ref logic s);
        tick();
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask : pulse
    task automatic send(input logic [2:0] c, input logic a);
        tick();
        cmd_valid = 1'b1;
        cmd_code = c;
        tick();
        cmd_valid = 1'b0;
        chk(acc, a);
    endtask : send
    function automatic logic [8:0] target(input logic [2:0] c);
        case (c)
            `CMD_SEEK: return ST_SEEK;
            `CMD_READ: return ST_READ;
            `CMD_WRITE: return ST_WRITE;
            `CMD_UNLOAD: return ST_UNLOAD_IDLE;
            default: return ST_IDLE;
        endcase
    endfunction : target
    task automatic reach(input logic [8:0] m);
        int n;
        n = 0;
        while (mode !== m && n < 64)
        begin
            tick();
            n++;
        end
        chk(mode, m);
    endtask : reach
    task automatic media_op();
        logic sr;
        // now and then a soft reset cuts the media command short instead of its completion
        sr = ($urandom_range(3) == 0);
        repeat ($urandom_range(4)) tick();
        if (sr)
            pulse(soft_rst);
        else
            pulse(op_done);
        chk({mode, done}, {ST_IDLE, !sr});
    endtask : media_op
    task automatic run(input logic [2:0] c);
        send(c, 1'b1);
        if (c == `CMD_STANDBY)
            chk(mode, ST_STANDBY);
        else if (c == `CMD_SLEEP)
        begin
            chk(mode, ST_SLEEP);
            send(`CMD_IDLE, 1'b0);
            if ($urandom_range(1))
                pulse(soft_rst);
            else
            begin
                reset_n = 1'b0;
                tick();
                reset_n = 1'b1;
                repeat (3) tick();
            end
            chk(mode, ST_STANDBY);
        end
        else
        begin
            chk({mode, spin}, {ST_SPINUP, 1'b1});
            reach(target(c));
            if (c == `CMD_IDLE)
                chk({done, rdy}, 2'h3);
            if (c == `CMD_UNLOAD)
                chk({spin, hload, lock}, 3'h5);
            if (c >= `CMD_SEEK)
                media_op();
            if (mode === ST_IDLE)
            begin
                send(3'($urandom_range(7, 5)), 1'b1);
                chk(mact, 1'b1);
                media_op();
            end
            if ($urandom_range(1))
            begin
                // park the heads with the spindle running, then reload them for a media command
                send(`CMD_UNLOAD, 1'b1);
                chk({mode, done, hload}, {ST_UNLOAD_IDLE, 2'h2});
                c = 3'($urandom_range(7, 5));
                send(c, 1'b1);
                chk(mode, ST_LOADING);
                reach(target(c));
                media_op();
            end
            c = $urandom_range(1) ? `CMD_SLEEP : `CMD_STANDBY;
            send(c, 1'b1);
            chk({done, lock, spin, late}, 4'hC);
            chk(mode, (c == `CMD_SLEEP) ? ST_SLEEP : ST_STANDBY);
            if (c == `CMD_SLEEP)
                pulse(soft_rst);
            chk(mode, ST_STANDBY);
        end
    endtask : run
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            err_count++;
            end_sim();
        end
    end
    initial
    begin
        void'($urandom(92708));
        repeat (8) @(posedge mclk);
        #1;
        chk({mode, lock, spin}, {ST_STANDBY, 2'h2});
        reset_n = 1'b1;
        repeat (3) tick();
        run(`CMD_SLEEP);
        run(`CMD_WRITE);
        repeat (20)
        begin
            lat = 4'($urandom_range(12, 1));
            run(3'($urandom_range(7, 1)));
        end
        end_sim();
    end
endmodule : disk_power_mode_manager_test
